// ==== logic/module_state_machine.sv ====
`timescale 1ns/10ps

// Contract
// RQ1 - Resetting drives everything into reset, then moves to Reset when shutdown completes.
// RQ2 - Reset holds all in reset at low power; leaves to startup when reset false.
// RQ3 - Any state from startup onward goes to Resetting when reset condition true.
// RQ4 - Startup through powering down go to fault when fault condition true.
// RQ5 - Startup finishes in time limit, sets state-change flag, enters low power.
// RQ6 - Low power state keeps management interface and whole memory accessible.
// RQ7 - Low power with request false moves to powering up, high power.
// RQ8 - Powering up with request true moves to powering down.
// RQ9 - Powering up moves to operational when power-up activities finish.
// RQ10 - Operational may draw full power; exit condition true moves to powering down.
// RQ11 - Powering down returns circuitry to low power, then enters low power.
// RQ12 - Fault waits for host; leaves only by reset condition or power removal.
// RQ13 - Fault state runs in low power mode where feasible.
// RQ14 - Priority: reset first, fault second, all other exits third.
// RQ15 - Reset condition is supply drop, reset pin or commanded reset bit.
// RQ16 - Low-power request is software bit, or allowed hardware pin request.
// RQ17 - Low-power exit needs request true and all lane paths deactivated.
// RQ18 - Powers up in Reset state and exposes current state encoding.
// RQ19 - High power in powering up, operational, powering down; low elsewhere.
module module_state_machine
    import msm_pkg::*;
#(
    parameter int unsigned NUM_LANES          = 8,
    parameter int unsigned STARTUP_LIMIT_CYC  = MGMT_STARTUP_LIMIT_CYC
)
(
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire logic                 supply_drop_reset,
    input  wire logic                 host_reset_pin,
    input  wire logic                 hw_low_power_pin,
    input  wire host_ctrl_s           host_ctrl,
    input  wire logic [NUM_LANES-1:0] path_deactivated_state,
    input  wire logic                 fault_condition,
    input  wire logic                 shutdown_done,
    input  wire logic                 mgmt_init_done,
    input  wire logic                 power_up_done,
    input  wire logic                 power_down_done,
    input  wire logic                 state_change_flag_clear,
    output module_state_e             module_state,
    output logic                      high_power_mode,
    output logic                      hold_in_reset,
    output logic                      mgmt_available,
    output logic                      state_change_flag,
    output logic                      soft_reset_clear,
    output logic                      mgmt_startup_overrun
);

    localparam int unsigned CNT_W = $clog2(STARTUP_LIMIT_CYC + 1);

    logic [2:0]           pins_sync;
    logic                 reset_condition;
    logic                 low_power_request_condition;
    logic                 all_paths_deactivated;
    logic                 low_power_exit_condition;
    module_state_e        state_reg;
    module_state_e        state_next;
    logic                 flag_reg;
    logic                 flag_next;
    logic [CNT_W-1:0]     cnt_reg;
    logic [CNT_W-1:0]     cnt_next;
    logic                 overrun_reg;
    logic                 overrun_next;
    logic                 hp_reg;
    logic                 hp_next;

    // Refuse parameters that leave no lane to watch or no startup time at all.
    if (NUM_LANES < 1 || STARTUP_LIMIT_CYC < 1)
    begin : g_param_check
        $error("module_state_machine needs lanes and a nonzero startup limit.");
    end

    // Pins from the host and the supply monitor are asynchronous.
    pin_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in ({supply_drop_reset, host_reset_pin, hw_low_power_pin}),
        .sync_out (pins_sync)
    );

    // Transition conditions built from synchronised pins and host bits.
    assign reset_condition = pins_sync[2] | pins_sync[1]
                           | host_ctrl.host_commanded_reset_bit; // RQ15
    assign low_power_request_condition = host_ctrl.sw_low_power_request_bit
        | (host_ctrl.hw_request_allow_bit & pins_sync[0]); // RQ16
    assign all_paths_deactivated = &path_deactivated_state;
    assign low_power_exit_condition = low_power_request_condition
                                    & all_paths_deactivated; // RQ17

    // Next state; reset beats fault, fault beats every other exit.
    // Every code is a legal state, so the case needs no default.
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            st_resetting:
                if (shutdown_done)
                    state_next = st_reset; // RQ1
            st_reset:
                if (!reset_condition)
                    state_next = st_mgmt_startup; // RQ2
            st_mgmt_startup:
                if (reset_condition)
                    state_next = st_resetting; // RQ3 RQ14
                else if (fault_condition)
                    state_next = st_fault; // RQ4 RQ14
                else if (mgmt_init_done)
                    state_next = st_low_power; // RQ5
            st_low_power:
                if (reset_condition)
                    state_next = st_resetting; // RQ3 RQ14
                else if (fault_condition)
                    state_next = st_fault; // RQ4 RQ14
                else if (!low_power_request_condition)
                    state_next = st_powering_up; // RQ7
            st_powering_up:
                if (reset_condition)
                    state_next = st_resetting; // RQ3 RQ14
                else if (fault_condition)
                    state_next = st_fault; // RQ4 RQ14
                else if (low_power_request_condition)
                    state_next = st_powering_down; // RQ8
                else if (power_up_done)
                    state_next = st_operational; // RQ9
            st_operational:
                if (reset_condition)
                    state_next = st_resetting; // RQ3 RQ14
                else if (fault_condition)
                    state_next = st_fault; // RQ4 RQ14
                else if (low_power_exit_condition)
                    state_next = st_powering_down; // RQ10
            st_powering_down:
                if (reset_condition)
                    state_next = st_resetting; // RQ3 RQ14
                else if (fault_condition)
                    state_next = st_fault; // RQ4 RQ14
                else if (power_down_done)
                    state_next = st_low_power; // RQ11
            st_fault:
                if (reset_condition)
                    state_next = st_resetting; // RQ12 RQ3
        endcase
    end

    // Startup timer; it saturates so a stuck startup cannot wrap and hide the overrun.
    always_comb
    begin
        cnt_next     = '0;
        overrun_next = overrun_reg;
        if (state_reg == st_mgmt_startup)
        begin
            if (cnt_reg < CNT_W'(STARTUP_LIMIT_CYC))
                cnt_next = cnt_reg + CNT_W'(1);
            else
            begin
                cnt_next     = cnt_reg;
                overrun_next = 1'b1; // RQ5
            end
        end
        else if (state_reg == st_reset)
            overrun_next = 1'b0;
    end

    // Setting on entry to low power from startup wins over a same-cycle clear.
    always_comb
    begin
        flag_next = flag_reg & ~state_change_flag_clear;
        if (state_reg == st_mgmt_startup && state_next == st_low_power)
            flag_next = 1'b1; // RQ5
    end

    // Power mode follows the next state so that it changes on the same edge as the state.
    // Low power is the default; fault deliberately stays low.
    always_comb
    begin
        hp_next = (state_next == st_powering_up) | (state_next == st_operational)
                | (state_next == st_powering_down); // RQ19 RQ13
    end

    // State register; power-on state is Reset.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            state_reg <= STATE_AFTER_RESET; // RQ18
        else
            state_reg <= state_next;
    end

    // Startup timer registers.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cnt_reg     <= '0;
            overrun_reg <= 1'b0;
        end
        else
        begin
            cnt_reg     <= cnt_next;
            overrun_reg <= overrun_next;
        end
    end

    // State-change flag register.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            flag_reg <= 1'b0;
        else
            flag_reg <= flag_next;
    end

    // Power mode register.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            hp_reg <= 1'b0;
        else
            hp_reg <= hp_next;
    end

    // Outputs come straight from registers or are decoded from registered state.
    assign module_state         = state_reg; // RQ18
    assign high_power_mode      = hp_reg;
    assign hold_in_reset        = (state_reg == st_resetting)
                                | (state_reg == st_reset); // RQ1 RQ2
    assign mgmt_available       = ~hold_in_reset; // RQ6
    assign state_change_flag    = flag_reg;
    assign soft_reset_clear     = (state_reg == st_reset);
    assign mgmt_startup_overrun = overrun_reg;

endmodule

// ==== logic/msm_pkg.sv ====
package msm_pkg;

    // Module states; the host reads the encoding through the status port.
    typedef enum logic [2:0]
    {
        st_resetting,
        st_reset,
        st_mgmt_startup,
        st_low_power,
        st_powering_up,
        st_operational,
        st_powering_down,
        st_fault
    } module_state_e;

    // Host control bits gathered into one carrier.
    typedef struct packed
    {
        logic host_commanded_reset_bit;
        logic sw_low_power_request_bit;
        logic hw_request_allow_bit;
    } host_ctrl_s;

    // Clock rate, the startup deadline, the power-on state and the synchroniser depth.
    localparam int unsigned  REF_CLK_HZ              = 25000000;
    localparam int unsigned  MGMT_STARTUP_LIMIT_US   = 2000;
    localparam int unsigned  MGMT_STARTUP_LIMIT_CYC  =
        (MGMT_STARTUP_LIMIT_US * (REF_CLK_HZ / 1000000));
    localparam module_state_e STATE_AFTER_RESET      = st_reset;
    localparam int unsigned  SYNC_STAGES             = 2;

endpackage

// ==== logic/pin_sync.sv ====
`timescale 1ns/10ps

// Two-stage synchroniser for a bundle of asynchronous pin levels.
module pin_sync
    import msm_pkg::*;
#(
    parameter int unsigned WIDTH = 1
)
(
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // Refuse an empty bundle when the design is elaborated.
    if (WIDTH < 1)
    begin : g_width_check
        $error("pin_sync needs at least one bit.");
    end

    // The first stage is read only by the second stage.
    always_comb
    begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    // Registers clear to zero, the deasserted level.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;

endmodule

// ==== sim/msm_checker_sva.sv ====
`timescale 1ns/10ps

// Only same-clock inputs are used here, since pin levels reach the state three edges late.
module msm_checker
    import msm_pkg::*;
#(
    parameter int unsigned NUM_LANES = 8
)
(
    input wire logic                 ref_clk,
    input wire logic                 reset,
    input wire host_ctrl_s           host_ctrl,
    input wire logic [NUM_LANES-1:0] path_deactivated_state,
    input wire logic                 fault_condition,
    input wire logic                 shutdown_done,
    input wire module_state_e        module_state,
    input wire logic                 high_power_mode,
    input wire logic                 hold_in_reset,
    input wire logic                 mgmt_available,
    input wire logic                 state_change_flag
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    // Ordinary exits count only while neither reset nor fault is pending.
    wire           cmd = host_ctrl.host_commanded_reset_bit;
    wire           calm = !cmd && !fault_condition;
    module_state_e st;
    assign st = module_state;
    property p_rst;
        cmd && st inside {[st_mgmt_startup:st_fault]} |=> st == st_resetting;
    endproperty
    a_rst: assert property (p_rst) else $error("commanded reset ignored");
    property p_flt;
        fault_condition && !cmd && st inside {[st_mgmt_startup:st_powering_down]}
            |=> st inside {st_fault, st_resetting};
    endproperty
    a_flt: assert property (p_flt) else $error("fault not entered");
    property p_hold;
        st == st_fault |=> st inside {st_fault, st_resetting};
    endproperty
    a_hold: assert property (p_hold) else $error("fault state left wrongly");
    property p_shut;
        st == st_resetting && !shutdown_done |=> st == st_resetting;
    endproperty
    a_shut: assert property (p_shut) else $error("resetting left early");
    property p_flag;
        st == st_mgmt_startup ##1 st == st_low_power |-> state_change_flag;
    endproperty
    a_flag: assert property (p_flag) else $error("state change flag missing");
    property p_pwr;
        high_power_mode == (st inside {[st_powering_up:st_powering_down]})
            && hold_in_reset == (st < st_mgmt_startup) && mgmt_available != hold_in_reset;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power or reset mode wrong");
    property p_abort;
        st == st_powering_up && calm && host_ctrl.sw_low_power_request_bit
            |=> st inside {st_powering_down, st_resetting};
    endproperty
    a_abort: assert property (p_abort) else $error("power up not abandoned");
    property p_exit;
        st == st_operational && calm && !(&path_deactivated_state) |=> st != st_powering_down;
    endproperty
    a_exit: assert property (p_exit) else $error("early power down");
    property p_down;
        st == st_operational && calm && host_ctrl.sw_low_power_request_bit
            && (&path_deactivated_state) |=> st inside {st_powering_down, st_resetting};
    endproperty
    a_down: assert property (p_down) else $error("power down not entered");
endmodule

bind module_state_machine msm_checker #(.NUM_LANES(NUM_LANES)) u_chk (.ref_clk, .reset,
    .host_ctrl, .path_deactivated_state, .fault_condition, .shutdown_done, .module_state,
    .high_power_mode, .hold_in_reset, .mgmt_available, .state_change_flag);

// ==== sim/host_model.sv ====
`timescale 1ns/10ps

// Host side of the block: reset and low-power pins plus the control bits it writes.
module host_model
    import msm_pkg::*;
(
    input  wire logic  ref_clk,
    input  wire logic  want_pin,
    input  wire logic  want_sw,
    input  wire logic  want_lp,
    input  wire logic  allow,
    input  wire logic  sw_lp,
    input  wire logic  soft_reset_clear,
    output logic       host_reset_pin,
    output logic       hw_low_power_pin,
    output host_ctrl_s host_ctrl
);
    logic cmd_reg = 1'b0;

    // The commanded reset bit stays set until the device clears it, so it is self-clearing.
    always @(posedge ref_clk)
    begin
        if (want_sw)
            cmd_reg <= 1'b1;
        else if (soft_reset_clear)
            cmd_reg <= 1'b0;
    end

    // A write shows at once, so a reset and a fault can meet on the same edge.
    assign host_ctrl = '{cmd_reg | want_sw, sw_lp, allow};
    assign host_reset_pin = want_pin;
    assign hw_low_power_pin = want_lp;
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/10ps

module tb
    import msm_pkg::*;
;
    logic          ref_clk = 1'b0, reset = 1'b1, supply_drop_reset = 1'b0, fclr = 1'b0;
    logic          want_sw = 1'b0, want_pin = 1'b0, want_lp = 1'b0, allow = 1'b0, sw_lp = 1'b1;
    logic          fault = 1'b0, shut = 1'b0, init = 1'b0, pu = 1'b0, pd = 1'b0;
    logic          high_power_mode, hold_in_reset, state_change_flag, soft_reset_clear;
    logic          host_reset_pin, hw_low_power_pin;
    logic          mgmt_available, mgmt_startup_overrun;
    logic [7:0]    path = 8'h00;
    logic [31:0]   seed = 32'he34d;
    host_ctrl_s    host_ctrl;
    module_state_e st, last_st = st_reset, exp_st;
    module_state_e exp_q[$];
    int            err_total = 0, comparisons = 0;

    always #20 ref_clk = ~ref_clk;

    host_model u_host (.ref_clk, .want_pin, .want_sw, .want_lp, .allow, .sw_lp,
        .soft_reset_clear, .host_reset_pin, .hw_low_power_pin, .host_ctrl);

    // A short startup limit keeps the overrun logic within reach of a short run.
    module_state_machine #(.NUM_LANES(8), .STARTUP_LIMIT_CYC(16)) u_dut (.ref_clk, .reset,
        .supply_drop_reset, .host_reset_pin, .hw_low_power_pin, .host_ctrl,
        .path_deactivated_state(path), .fault_condition(fault), .shutdown_done(shut),
        .mgmt_init_done(init), .power_up_done(pu), .power_down_done(pd),
        .state_change_flag_clear(fclr), .module_state(st), .high_power_mode, .hold_in_reset,
        .mgmt_available, .state_change_flag, .soft_reset_clear, .mgmt_startup_overrun);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] want);
        comparisons++;
        if (got !== want)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Waits, bounded, until every expected state has been seen.
    task automatic settle(input string name);
        int n = 0;
        while (exp_q.size() > 0 && n < 40)
        begin
            @(negedge ref_clk);
            n++;
        end
        check(8'(exp_q.size()), 8'h00);
        $display("test %s done", name);
    endtask

    task automatic expect_st(input module_state_e s);
        exp_q.push_back(s);
    endtask

    // Any state change takes the oldest note; an unexpected change can never match.
    always @(negedge ref_clk)
    begin
        if (!reset && st !== last_st)
        begin
            exp_st = (exp_q.size() > 0) ? exp_q.pop_front() : last_st;
            check(st, exp_st);
            check(high_power_mode, exp_st inside {[st_powering_up:st_powering_down]});
            check(hold_in_reset, exp_st inside {st_resetting, st_reset});
            check(mgmt_available, !(exp_st inside {st_resetting, st_reset}));
            last_st = st;
        end
    end

    initial
    begin
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        check(st, st_reset);
        reset = 1'b0;
        expect_st(st_mgmt_startup);
        settle("startup");
        init = 1'b1;
        expect_st(st_low_power);
        settle("init");
        check(state_change_flag, 1'b1);
        check(mgmt_startup_overrun, 1'b0);
        fclr = 1'b1;
        allow = 1'b1;
        want_lp = 1'b1;
        repeat (4) @(negedge ref_clk);
        fclr = 1'b0;
        sw_lp = 1'b0;
        check(state_change_flag, 1'b0);
        repeat (4) @(negedge ref_clk);
        want_lp = 1'b0;
        expect_st(st_powering_up);
        settle("hw request");
        pu = 1'b1;
        expect_st(st_operational);
        settle("power up");
        pu = 1'b0;
        sw_lp = 1'b1;
        repeat (4)
        begin
            path = 8'(rnd()) & ~(8'h01 << (rnd() % 8));
            @(negedge ref_clk);
        end
        path = 8'hff;
        expect_st(st_powering_down);
        settle("power down");
        pd = 1'b1;
        expect_st(st_low_power);
        settle("low power");
        pd = 1'b0;
        sw_lp = 1'b0;
        expect_st(st_powering_up);
        settle("again");
        sw_lp = 1'b1;
        expect_st(st_powering_down);
        settle("abort");
        {pd, pu, sw_lp} = 3'b110;
        expect_st(st_low_power);
        expect_st(st_powering_up);
        expect_st(st_operational);
        settle("resume");
        {want_sw, fault} = 2'b11;
        expect_st(st_resetting);
        @(negedge ref_clk);
        want_sw = 1'b0;
        repeat (4) @(negedge ref_clk);
        settle("priority");
        shut = 1'b1;
        expect_st(st_reset);
        expect_st(st_mgmt_startup);
        expect_st(st_fault);
        settle("fault");
        repeat (4) @(negedge ref_clk);
        want_pin = 1'b1;
        expect_st(st_resetting);
        expect_st(st_reset);
        settle("pin reset");
        {fault, want_pin} = 2'b00;
        expect_st(st_mgmt_startup);
        expect_st(st_low_power);
        expect_st(st_powering_up);
        expect_st(st_operational);
        settle("release");
        supply_drop_reset = 1'b1;
        init = 1'b0;
        expect_st(st_resetting);
        expect_st(st_reset);
        settle("supply drop");
        supply_drop_reset = 1'b0;
        expect_st(st_mgmt_startup);
        settle("slow startup");
        repeat (20) @(negedge ref_clk);
        check(mgmt_startup_overrun, 1'b1);
        init = 1'b1;
        expect_st(st_low_power);
        expect_st(st_powering_up);
        expect_st(st_operational);
        settle("overrun");
        wrap_up();
    end

    // The tests need some 100 cycles; about thirty times that is taken as a hang.
    initial
    begin
        #120000;
        err_total++;
        wrap_up();
    end
endmodule
